// ==== fts_pkg.sv ====
// Shared constants for the flow-totalizing sample trigger.
// Assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus.
`default_nettype none

package fts_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned FTS_CLK_PERIOD_NS = 64'd10;          // Core clock period.
  localparam longint unsigned FTS_READ_PERIOD_NS = 64'd60000000000; // One minute.
  localparam longint unsigned FTS_READ_CYC = FTS_READ_PERIOD_NS / FTS_CLK_PERIOD_NS;
  localparam int              FTS_CNT_W = 36;                      // Minute counter width.

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FTS_OFF_CTRL  = 8'h00; // Start and stop commands.
  localparam logic [7:0] FTS_OFF_STAT  = 8'h04; // Run state, read only.
  localparam logic [7:0] FTS_OFF_MODE  = 8'h08; // Mode code entry.
  localparam logic [7:0] FTS_OFF_MAXR  = 8'h0C; // Maximum flow rate digits.
  localparam logic [7:0] FTS_OFF_MINR  = 8'h10; // Minimum flow rate digits.
  localparam logic [7:0] FTS_OFF_FMUL  = 8'h14; // Flow multiplier.
  localparam logic [7:0] FTS_OFF_TRIG  = 8'h18; // Trigger volume digits.
  localparam logic [7:0] FTS_OFF_TMUL  = 8'h1C; // Trigger multiplier.
  localparam logic [7:0] FTS_OFF_NBOT  = 8'h20; // Configured bottle count.
  localparam logic [7:0] FTS_OFF_TOTAL = 8'h24; // Accumulated volume, low word.
  localparam logic [7:0] FTS_OFF_ISTAT = 8'h28; // Sticky event bits, write one to clear.
  localparam logic [7:0] FTS_OFF_IMASK = 8'h2C; // Event enable mask.
  localparam logic [7:0] FTS_OFF_FLOW  = 8'h30; // Last scaled flow reading.

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int          FTS_DIG_W      = 14;       // Width of a four-digit entry.
  localparam logic [13:0] FTS_DIG_MAX    = 14'h270F; // Largest four-digit entry.
  localparam int          FTS_MUL_W      = 16;       // Multiplier width.
  localparam logic [7:0]  FTS_MODE_CODE  = 8'h05;    // Mode code of this program.
  localparam int          FTS_ADC_W      = 12;       // Analog reading width.
  localparam int          FTS_BOT_W      = 5;        // Bottle index width.
  localparam logic [4:0]  FTS_NBOT_RST   = 5'h18;    // Bottle count after reset.
  localparam int          FTS_CTRL_START = 0;        // Start command bit.
  localparam int          FTS_CTRL_STOP  = 1;        // Stop command bit.
  localparam int          FTS_EV_N       = 4;        // Number of event bits.
  localparam int          FTS_EV_TRIG    = 0;        // Trigger reached.
  localparam int          FTS_EV_DEPO    = 1;        // Sample deposited.
  localparam int          FTS_EV_END     = 2;        // Program ended.
  localparam int          FTS_EV_SEQ     = 3;        // Entry refused.
  localparam logic [3:0]  FTS_STEP_DONE  = 4'h6;     // All parameters entered.

  // Run states of the sampler.
  typedef enum logic [2:0] {
    FTS_IDLE  = 3'b000,
    FTS_WAIT  = 3'b001,
    FTS_SPOUT = 3'b010,
    FTS_TAKE  = 3'b011,
    FTS_DEPO  = 3'b100,
    FTS_ADV   = 3'b101,
    FTS_DONE  = 3'b110
  } fts_state_t;

endpackage

`default_nettype wire

// ==== fts_scale.sv ====
// Linear scaler from an analog reading to a flow rate.
// Assumes a one-cycle go pulse while inputs are stable.
`default_nettype none

module fts_scale
(
  input  wire logic        core_clk_i, // Core clock.
  input  wire logic        reset_n_i,  // Synchronous reset, active low.
  input  wire logic        go_i,       // Start one conversion.
  input  wire logic [11:0] adc_i,      // Reading, zero at the low end.
  input  wire logic [31:0] min_eff_i,  // Flow at the low end.
  input  wire logic [31:0] max_eff_i,  // Flow at the high end.
  output logic      [31:0] flow_o,     // Scaled flow rate.
  output logic             valid_o     // One-cycle result strobe.
);

  // ----------------------------------------------------------------
  // Mapping
  // ----------------------------------------------------------------
  logic [31:0] span;    // Width of the flow range.
  logic [43:0] product; // Span times reading.
  logic [31:0] flow;    // Mapped result.

  // An inverted range maps every reading to the low end.
  assign span    = (max_eff_i > min_eff_i) ? (max_eff_i - min_eff_i) : 32'h0000_0000;
  assign product = 44'(span) * 44'(adc_i);
  assign flow    = min_eff_i + product[43:12];

  // Result register; the strobe follows go by one cycle.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      flow_o  <= 32'h0000_0000;
      valid_o <= 1'b0;
    end
    else
    begin
      if (go_i)
      begin
        flow_o <= flow;
      end
      valid_o <= go_i;
    end
  end

endmodule // fts_scale

`default_nettype wire

// ==== fts_top.sv ====
// Flow-totalizing sample trigger with an AHB-Lite register slave.
// Assumes an actuator that acknowledges each step with action_done_i.
`default_nettype none

module fts_top
#(
  parameter logic [35:0] READ_CYCLES = 36'(fts_pkg::FTS_READ_CYC) // Cycles per minute.
)
(
  input  wire logic        core_clk_i,    // Core clock, 100 MHz.
  input  wire logic        reset_n_i,     // Synchronous reset, active low.
  input  wire logic        hsel_i,        // AHB slave select.
  input  wire logic [31:0] haddr_i,       // AHB address.
  input  wire logic [1:0]  htrans_i,      // AHB transfer type.
  input  wire logic        hwrite_i,      // AHB write flag.
  input  wire logic [2:0]  hsize_i,       // AHB size, word only.
  input  wire logic [31:0] hwdata_i,      // AHB write data.
  input  wire logic        hready_i,      // AHB bus ready.
  output logic      [31:0] hrdata_o,      // AHB read data.
  output logic             hreadyout_o,   // AHB slave ready.
  output logic             hresp_o,       // AHB response, always OKAY.
  input  wire logic [11:0] adc_code_i,    // Analog flow reading.
  input  wire logic        bottle_full_i, // Bottle full pin.
  input  wire logic        action_done_i, // Actuator step finished.
  output logic             spout_adv_o,   // Advance spout, held until done.
  output logic             sample_take_o, // Take a sample, held until done.
  output logic             deposit_o,     // Deposit sample, held until done.
  output logic             bottle_adv_o,  // Step to next bottle, held until done.
  output logic             running_o,     // Program running.
  output logic             irq_o          // Interrupt, level.
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // True in the states that run the program.
  function automatic logic fts_active(input fts_pkg::fts_state_t s);
    fts_active = (s != fts_pkg::FTS_IDLE) && (s != fts_pkg::FTS_DONE);
  endfunction

  // True when a data-phase write hits the given offset.
  function automatic logic fts_wr(input logic act, input logic [7:0] a,
                                  input logic [7:0] off);
    fts_wr = act && (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fts_pkg::fts_state_t state_r;   // Run state.
  fts_pkg::fts_state_t state_nxt; // Next run state.
  logic [13:0] max_r;             // Maximum rate digits.
  logic [13:0] min_r;             // Minimum rate digits.
  logic [15:0] fmul_r;            // Flow multiplier.
  logic [13:0] trig_r;            // Trigger digits.
  logic [15:0] tmul_r;            // Trigger multiplier.
  logic [4:0]  nbot_r;            // Configured bottles.
  logic [3:0]  step_r;            // Entry progress.
  logic [3:0]  step_nxt;          // Next entry progress.
  logic [4:0]  bot_r;             // Current bottle index.
  logic        first_r;           // No trigger yet since start.
  logic [39:0] total_r;           // Accumulated volume.
  logic [39:0] total_nxt;         // Next accumulated volume.
  logic [35:0] min_cnt_r;         // Minute counter.
  logic [11:0] adc_r;             // Reading held for the scaler.
  logic        go_r;              // Scaler start pulse.
  logic [31:0] flow;              // Scaled reading.
  logic        flow_vld;          // Scaled reading ready.
  logic [3:0]  ist_r;             // Sticky event bits.
  logic [3:0]  imask_r;           // Event mask.
  logic [3:0]  ev;                // Events this cycle.
  logic [2:0]  full_s;            // Bottle full synchroniser.
  logic        full_r;            // Filtered bottle full level.
  logic        wr_act_r;          // Write data phase pending.
  logic [7:0]  wad_r;             // Write address.
  logic        rd_take;           // Read address phase taken.
  logic [31:0] rd_mux;            // Read data selection.
  logic [31:0] max_eff;           // Scaled maximum rate.
  logic [31:0] min_eff;           // Scaled minimum rate.
  logic [39:0] trig_eff;          // Effective trigger volume.
  logic        tick;              // Minute elapsed.
  logic        hit_trig;          // Trigger reached.
  logic        start_cmd;         // Accepted start.
  logic        stop_cmd;          // Stop command.
  logic        prog_wr;           // Any entry write.
  logic        seq_ok;            // Entry write in order.
  logic        val_ok;            // Entry value in range.
  logic        last_bot;          // Current bottle is the last.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign rd_take  = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  assign stop_cmd = fts_wr(wr_act_r, wad_r, fts_pkg::FTS_OFF_CTRL)
                    && hwdata_i[fts_pkg::FTS_CTRL_STOP];
  assign start_cmd = fts_wr(wr_act_r, wad_r, fts_pkg::FTS_OFF_CTRL)
                     && hwdata_i[fts_pkg::FTS_CTRL_START] && !stop_cmd
                     && !fts_active(state_r)
                     && (step_r == fts_pkg::FTS_STEP_DONE);
  assign prog_wr = wr_act_r && (wad_r >= fts_pkg::FTS_OFF_MODE)
                   && (wad_r <= fts_pkg::FTS_OFF_TMUL);

  // Each parameter is taken only at its turn and while not running.
  assign seq_ok = !fts_active(state_r) &&
                  ((wad_r == fts_pkg::FTS_OFF_MODE) ||
                   (step_r == 4'((wad_r - fts_pkg::FTS_OFF_MODE) >> 2)));
  assign val_ok = (wad_r == fts_pkg::FTS_OFF_MODE) ? (hwdata_i == 32'(fts_pkg::FTS_MODE_CODE))
                : ((wad_r == fts_pkg::FTS_OFF_FMUL) || (wad_r == fts_pkg::FTS_OFF_TMUL))
                ? (hwdata_i[31:16] == 16'h0000)
                : (hwdata_i <= 32'(fts_pkg::FTS_DIG_MAX));
  assign step_nxt = (wad_r == fts_pkg::FTS_OFF_MODE) ? 4'h1 : (step_r + 4'h1);

  // Read selection at the address phase.
  always_comb
  begin
    case (haddr_i[7:0])
      fts_pkg::FTS_OFF_STAT:  rd_mux = {11'h000, full_r, 4'h0, step_r,
                                        3'h0, bot_r, 1'b0, state_r};
      fts_pkg::FTS_OFF_MAXR:  rd_mux = 32'(max_r);
      fts_pkg::FTS_OFF_MINR:  rd_mux = 32'(min_r);
      fts_pkg::FTS_OFF_FMUL:  rd_mux = 32'(fmul_r);
      fts_pkg::FTS_OFF_TRIG:  rd_mux = 32'(trig_r);
      fts_pkg::FTS_OFF_TMUL:  rd_mux = 32'(tmul_r);
      fts_pkg::FTS_OFF_NBOT:  rd_mux = 32'(nbot_r);
      fts_pkg::FTS_OFF_TOTAL: rd_mux = total_r[31:0];
      fts_pkg::FTS_OFF_ISTAT: rd_mux = 32'(ist_r);
      fts_pkg::FTS_OFF_IMASK: rd_mux = 32'(imask_r);
      fts_pkg::FTS_OFF_FLOW:  rd_mux = flow;
      default:                rd_mux = 32'h0000_0000; // Unmapped reads as zero.
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------------

  // Zero wait states: capture the write address, return read data.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_act_r    <= 1'b0;
      wad_r       <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_act_r <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      wad_r    <= haddr_i[7:0];
      if (rd_take)
      begin
        hrdata_o <= rd_mux;
      end
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Parameter entry
  // ----------------------------------------------------------------

  // In-order entry of the mode code and the five parameters.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      step_r  <= 4'h0;
      max_r   <= 14'h0000;
      min_r   <= 14'h0000;
      fmul_r  <= 16'h0001;
      trig_r  <= 14'h0000;
      tmul_r  <= 16'h0001;
      nbot_r  <= fts_pkg::FTS_NBOT_RST;
      imask_r <= 4'h0;
    end
    else
    begin
      if (prog_wr && seq_ok && val_ok)
      begin
        step_r <= step_nxt;
        case (wad_r)
          fts_pkg::FTS_OFF_MAXR: max_r  <= hwdata_i[13:0];
          fts_pkg::FTS_OFF_MINR: min_r  <= hwdata_i[13:0];
          fts_pkg::FTS_OFF_FMUL: fmul_r <= hwdata_i[15:0];
          fts_pkg::FTS_OFF_TRIG: trig_r <= hwdata_i[13:0];
          fts_pkg::FTS_OFF_TMUL: tmul_r <= hwdata_i[15:0];
          default:               step_r <= step_nxt;
        endcase
      end
      if (fts_wr(wr_act_r, wad_r, fts_pkg::FTS_OFF_NBOT) && !fts_active(state_r))
      begin
        nbot_r <= (hwdata_i[4:0] == 5'h00) ? 5'h01 : hwdata_i[4:0];
      end
      if (fts_wr(wr_act_r, wad_r, fts_pkg::FTS_OFF_IMASK))
      begin
        imask_r <= hwdata_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Scaling and totalizing
  // ----------------------------------------------------------------
  assign max_eff  = 32'(max_r) * 32'(fmul_r);
  assign min_eff  = 32'(min_r) * 32'(fmul_r);
  assign trig_eff = 40'(trig_r) * 40'(tmul_r);
  assign tick     = fts_active(state_r) && (min_cnt_r == (READ_CYCLES - 36'h1));
  assign hit_trig = (state_r == fts_pkg::FTS_WAIT) && (trig_eff != 40'h0)
                    && (total_r >= trig_eff);
  assign total_nxt = total_r + (flow_vld ? 40'(flow) : 40'h0)
                     - (hit_trig ? trig_eff : 40'h0);
  assign last_bot = (bot_r + 5'h01) >= nbot_r;

  // The meter must share the programmed range for readings to match.
  fts_scale u_scale
  (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .go_i       (go_r),
    .adc_i      (adc_r),
    .min_eff_i  (min_eff),
    .max_eff_i  (max_eff),
    .flow_o     (flow),
    .valid_o    (flow_vld)
  );

  // Minute timer, reading capture and running total.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      min_cnt_r <= 36'h0_0000_0000;
      adc_r     <= 12'h000;
      go_r      <= 1'b0;
      total_r   <= 40'h00_0000_0000;
    end
    else
    begin
      go_r <= tick;
      if (start_cmd)
      begin
        min_cnt_r <= 36'h0_0000_0000;
        total_r   <= 40'h00_0000_0000;
      end
      else
      begin
        min_cnt_r <= (tick || !fts_active(state_r)) ? 36'h0_0000_0000
                                                    : (min_cnt_r + 36'h1);
        total_r   <= total_nxt;
      end
      if (tick)
      begin
        adc_r <= adc_code_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bottle full input
  // ----------------------------------------------------------------

  // Three stages; the level changes when the last two agree.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      full_s <= 3'b000;
      full_r <= 1'b0;
    end
    else
    begin
      full_s <= {full_s[1:0], bottle_full_i};
      if (full_s[1] == full_s[2])
      begin
        full_r <= full_s[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample sequence
  // ----------------------------------------------------------------

  // Next state of the sampling program.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fts_pkg::FTS_IDLE, fts_pkg::FTS_DONE:
        if (start_cmd)
          state_nxt = fts_pkg::FTS_WAIT;
      fts_pkg::FTS_WAIT:
        if (hit_trig)
          state_nxt = first_r ? fts_pkg::FTS_SPOUT : fts_pkg::FTS_TAKE;
      fts_pkg::FTS_SPOUT:
        if (action_done_i)
          state_nxt = fts_pkg::FTS_TAKE;
      fts_pkg::FTS_TAKE:
        if (action_done_i)
          state_nxt = fts_pkg::FTS_DEPO;
      fts_pkg::FTS_DEPO:
        if (action_done_i)
          state_nxt = last_bot ? fts_pkg::FTS_DONE : fts_pkg::FTS_ADV;
      fts_pkg::FTS_ADV:
        if (action_done_i)
          state_nxt = fts_pkg::FTS_WAIT;
      default:
        state_nxt = fts_pkg::FTS_IDLE;
    endcase
    if (fts_active(state_r) && full_r)
      state_nxt = fts_pkg::FTS_DONE;
    if (stop_cmd)
      state_nxt = fts_pkg::FTS_IDLE;
  end

  // Events raised by the sequence and by refused entries.
  assign ev[fts_pkg::FTS_EV_TRIG] = hit_trig;
  assign ev[fts_pkg::FTS_EV_DEPO] = (state_r == fts_pkg::FTS_DEPO) && action_done_i;
  assign ev[fts_pkg::FTS_EV_END]  = fts_active(state_r)
                                    && (state_nxt == fts_pkg::FTS_DONE);
  assign ev[fts_pkg::FTS_EV_SEQ]  = prog_wr && !(seq_ok && val_ok);

  // State, bottle position and actuator outputs.
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r       <= fts_pkg::FTS_IDLE;
      bot_r         <= 5'h00;
      first_r       <= 1'b1;
      spout_adv_o   <= 1'b0;
      sample_take_o <= 1'b0;
      deposit_o     <= 1'b0;
      bottle_adv_o  <= 1'b0;
      running_o     <= 1'b0;
      irq_o         <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (start_cmd)
      begin
        bot_r   <= 5'h00;
        first_r <= 1'b1;
      end
      else if ((state_r == fts_pkg::FTS_ADV) && action_done_i)
      begin
        bot_r <= bot_r + 5'h01;
      end
      if (hit_trig)
      begin
        first_r <= 1'b0;
      end
      spout_adv_o   <= (state_nxt == fts_pkg::FTS_SPOUT);
      sample_take_o <= (state_nxt == fts_pkg::FTS_TAKE);
      deposit_o     <= (state_nxt == fts_pkg::FTS_DEPO);
      bottle_adv_o  <= (state_nxt == fts_pkg::FTS_ADV);
      running_o     <= fts_active(state_nxt);
      irq_o         <= |(ist_r & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------

  // Write one clears a bit; a new event in the same cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < fts_pkg::FTS_EV_N; gi = gi + 1)
    begin : g_ist
      always_ff @(posedge core_clk_i)
      begin
        if (!reset_n_i)
          ist_r[gi] <= 1'b0;
        else if (ev[gi])
          ist_r[gi] <= 1'b1;
        else if (fts_wr(wr_act_r, wad_r, fts_pkg::FTS_OFF_ISTAT) && hwdata_i[gi])
          ist_r[gi] <= 1'b0;
      end
    end
  endgenerate

endmodule // fts_top

`default_nettype wire

// ==== fts_meter.sv ====
// Behavioural flow meter that drives the sampler's analog flow reading.
// Assumes it shares the core clock and the sampler's flow range.
`default_nettype none
module fts_meter
(
  input  wire logic        core_clk_i, // Core clock.
  input  wire logic [31:0] flow_i,     // Flow the meter measures.
  input  wire logic [31:0] min_i,      // Flow at the low end of the range.
  input  wire logic [31:0] max_i,      // Flow at the high end of the range.
  output logic      [11:0] adc_code_o  // Reading handed to the sampler.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The reading is linear over the same range that the sampler uses.
  always_ff @(posedge core_clk_i)
  begin
    if (flow_i >= max_i)
      adc_code_o <= 12'hFFF;
    else
      adc_code_o <= 12'((64'(flow_i - min_i) << 12) / 64'(max_i - min_i));
  end
endmodule // fts_meter
`default_nettype wire

// ==== fts_chk.sv ====
// Checker of the sample trigger's bus answer and actuator steps.
// Assumes it is bound into fts_top and sees only its ports.
`default_nettype none
module fts_chk
(
  input wire logic core_clk_i,    // Core clock.
  input wire logic reset_n_i,     // Reset, active low.
  input wire logic hreadyout_o,   // Slave ready.
  input wire logic hresp_o,       // Slave response.
  input wire logic bottle_full_i, // Bottle full pin.
  input wire logic action_done_i, // Actuator acknowledge.
  input wire logic spout_adv_o,   // Spout step.
  input wire logic sample_take_o, // Take step.
  input wire logic deposit_o,     // Deposit step.
  input wire logic bottle_adv_o,  // Bottle step.
  input wire logic running_o      // Program running.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // All four actuator steps side by side.
  wire logic [3:0] steps = {bottle_adv_o, deposit_o, sample_take_o, spout_adv_o};
  // A step output seen together with its acknowledge.
  sequence s_done(sig);
    sig && action_done_i;
  endsequence
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus answer not okay");
  a_one_step: assert property ($onehot0(steps)) else $error("two steps at once");
  a_step_running: assert property (|steps |-> running_o) else $error("step while idle");
  a_step_holds: assert property (|steps && !action_done_i |=> $stable(steps))
    else $error("step dropped early");
  a_spout_take: assert property (s_done(spout_adv_o) |=> !spout_adv_o ##[0:1] sample_take_o)
    else $error("take did not follow spout");
  a_take_depo: assert property (s_done(sample_take_o) |=> !sample_take_o ##[0:1] deposit_o)
    else $error("deposit did not follow take");
  a_depo_next: assert property (s_done(deposit_o) |=> ##[0:1] (bottle_adv_o || !running_o))
    else $error("no bottle step or end after deposit");
  a_full_ends: assert property (bottle_full_i [*8] |-> !running_o)
    else $error("still running with bottle full");
endmodule // fts_chk
bind fts_top fts_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .bottle_full_i(bottle_full_i),
  .action_done_i(action_done_i), .spout_adv_o(spout_adv_o), .sample_take_o(sample_take_o),
  .deposit_o(deposit_o), .bottle_adv_o(bottle_adv_o), .running_o(running_o));
`default_nettype wire

// ==== test_flow_totalizing_sampler_trigger.sv ====
// Testbench: parameter entry, a two-bottle flow run and a bottle-full end.
// Assumes a short minute of 20 cycles and an actuator that acks each step.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_flow_totalizing_sampler_trigger;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0, reset_n_i, hsel_i, hwrite_i, bottle_full_i, action_done_i;
  logic        hreadyout_o, hresp_o, spout_adv_o, sample_take_o, deposit_o, bottle_adv_o;
  logic        running_o, irq_o;
  logic [1:0]  htrans_i;
  logic [11:0] adc;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic [3:0]  prev;
  int          n_sp, n_dep, n_adv, bad_count, comparisons;
  always #5 core_clk_i = ~core_clk_i;
  fts_top #(.READ_CYCLES(36'd20)) uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .adc_code_i(adc),
    .bottle_full_i(bottle_full_i), .action_done_i(action_done_i), .spout_adv_o(spout_adv_o),
    .sample_take_o(sample_take_o), .deposit_o(deposit_o), .bottle_adv_o(bottle_adv_o),
    .running_o(running_o), .irq_o(irq_o));
  // The meter sees 1000 units per minute over a 0 to 4000 range.
  fts_meter meter (.core_clk_i(core_clk_i), .flow_i(32'h3E8), .min_i(32'h0),
    .max_i(32'hFA0), .adc_code_o(adc));
  // Actuator acks every step one cycle late; spout, deposit and bottle step rises are counted.
  always @(posedge core_clk_i)
  begin
    action_done_i <= reset_n_i && !action_done_i
                     && (spout_adv_o | sample_take_o | deposit_o | bottle_adv_o);
    prev <= {bottle_adv_o, deposit_o, sample_take_o, spout_adv_o};
    n_sp += int'(spout_adv_o && !prev[0]);
    n_dep += int'(deposit_o && !prev[2]);
    n_adv += int'(bottle_adv_o && !prev[3]);
  end
  // One single AHB-Lite word transfer; entered and left just after an edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  // Refused entries, the mode code, then the five parameters in order.
  task automatic t_entry;
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q, 32'h0)
    wr(fts_pkg::FTS_OFF_TRIG, 32'h64);
    wr(fts_pkg::FTS_OFF_MODE, 32'h4);
    rd(fts_pkg::FTS_OFF_ISTAT);
    `CHK(q[3:0], 4'h8)
    `CHK(irq_o, 1'b0)
    wr(fts_pkg::FTS_OFF_MODE, 32'h5);
    wr(fts_pkg::FTS_OFF_MAXR, 32'h190);
    wr(fts_pkg::FTS_OFF_MINR, 32'h0);
    wr(fts_pkg::FTS_OFF_FMUL, 32'hA);
    wr(fts_pkg::FTS_OFF_TRIG, 32'h64);
    wr(fts_pkg::FTS_OFF_TMUL, 32'hF);
    wr(fts_pkg::FTS_OFF_NBOT, 32'h2);
    wr(fts_pkg::FTS_OFF_ISTAT, 32'hF);
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q[15:12], 4'h6)
    rd(fts_pkg::FTS_OFF_ISTAT);
    `CHK(q, 32'h0)
    rd(8'h3C);
    `CHK(q, 32'h0)
    $display("entry test done");
  endtask
  // Two triggers of 1500 units fill two bottles, then the program ends.
  task automatic t_run;
    wr(fts_pkg::FTS_OFF_IMASK, 32'h4);
    wr(fts_pkg::FTS_OFF_CTRL, 32'h1);
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q[2:0], 3'h1)
    q = 32'h0;
    for (int i = 0; i < 30 && q === 32'h0; i++) rd(fts_pkg::FTS_OFF_TOTAL);
    `CHK(q, 32'h3E8)
    rd(fts_pkg::FTS_OFF_FLOW);
    `CHK(q, 32'h3E8)
    for (int i = 0; i < 300 && spout_adv_o !== 1'b1; i++) @(posedge core_clk_i);
    `CHK(sample_take_o, 1'b0)
    rd(fts_pkg::FTS_OFF_TOTAL);
    `CHK(q, 32'h1F4)
    for (int i = 0; i < 500 && running_o !== 1'b0; i++) @(posedge core_clk_i);
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q[8:0], 9'h016)
    `CHK({n_sp, n_dep, n_adv}, {32'h1, 32'h2, 32'h1})
    `CHK(irq_o, 1'b1)
    wr(fts_pkg::FTS_OFF_ISTAT, 32'hF);
    repeat (2) @(posedge core_clk_i);
    `CHK(irq_o, 1'b0)
    $display("run test done");
  endtask
  // Restart without re-entry, then a bottle-full report ends the program.
  task automatic t_full;
    wr(fts_pkg::FTS_OFF_CTRL, 32'h3);
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q[2:0], 3'h0)
    wr(fts_pkg::FTS_OFF_CTRL, 32'h1);
    rd(fts_pkg::FTS_OFF_TOTAL);
    `CHK(q, 32'h0)
    bottle_full_i <= 1'b1;
    for (int i = 0; i < 50 && running_o !== 1'b0; i++) @(posedge core_clk_i);
    repeat (6) @(posedge core_clk_i);
    rd(fts_pkg::FTS_OFF_STAT);
    `CHK(q[8:0], 9'h006)
    bottle_full_i <= 1'b0;
    $display("bottle full test done");
  endtask
  task automatic stop_test;
    $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence after a four-cycle reset.
  initial
  begin
    {reset_n_i, hsel_i, hwrite_i, bottle_full_i} = 4'h4;
    {htrans_i, haddr_i, hwdata_i} = '0;
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_entry();
    t_run();
    t_full();
    stop_test();
  end
  // Watchdog well past the few hundred cycles the tests need.
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    bad_count++;
    stop_test();
  end
endmodule // test_flow_totalizing_sampler_trigger
`default_nettype wire
